// [hw/hsf_pkg.sv]
// Constants and types for the host event status flag block
// Contract
// R01 - Bit 15 mirrors live async schedule state
// R02 - Bit 14 mirrors live periodic schedule state
// R03 - Bit 13 read-only empty async list detect
// R04 - Stopped flag zero whenever run_stop is one
// R05 - Stopped flag set only once engine idle
// R06 - Bits 31-16 and 11-6 read zero
// R07 - Doorbell arms; next advance sets bit 5
// R08 - System bus fault sets bit 4
// R09 - Frame counter wrap sets bit 3
// R10 - Owned port change rise sets bit 2
// R11 - Force-resume rise also sets port change
// R12 - Connect change on released port sets bit 2
// R13 - Transfer error sets bit 1
// R14 - Completed descriptor with irq_on_complete sets bit 0
// R15 - Interrupt enable register resets to zero
// R16 - Enabled flag raises irq at threshold
// R17 - run_stop one runs schedules; zero requests stop
// R18 - Software rings doorbell via command register
// R19 - 14-bit frame counter increments per frame
package hsf_pkg;

  localparam int          NUM_PORTS      = 2;
  localparam int          FRAME_W        = 14;

  localparam logic [7:0]  ADDR_COMMAND   = 8'h20;
  localparam logic [7:0]  ADDR_STATUS    = 8'h24;
  localparam logic [7:0]  ADDR_INT_EN    = 8'h28;
  localparam logic [7:0]  ADDR_FRAME     = 8'h2c;

  localparam int          CMD_RUN_STOP   = 0;
  localparam int          CMD_DOORBELL   = 6;

  localparam int          ST_DONE        = 0;
  localparam int          ST_ERROR       = 1;
  localparam int          ST_PORT        = 2;
  localparam int          ST_WRAP        = 3;
  localparam int          ST_FAULT       = 4;
  localparam int          ST_ADVANCE     = 5;
  localparam int          ST_STOPPED     = 12;
  localparam int          ST_EMPTY       = 13;
  localparam int          ST_PERIODIC    = 14;
  localparam int          ST_ASYNC       = 15;

  localparam logic [5:0]  FLAGS_RESET    = 6'h00;
  localparam logic [5:0]  INT_EN_RESET   = 6'h00;
  localparam logic        STOPPED_RESET  = 1'b1;
  localparam logic [31:0] STATUS_RESET   = 32'h0000_1000;

  // Engine event pulses, one cycle each
  typedef struct packed {
    logic threshold_tick;
    logic frame_end;
    logic async_advance;
    logic bus_fault;
    logic xfer_error;
    logic xfer_done;
    logic irq_on_complete;
  } hsf_evt_t;

  // Live schedule state from the engine
  typedef struct packed {
    logic async_sched_active;
    logic periodic_sched_active;
    logic empty_list_detect;
    logic engine_idle;
    logic hw_stop;
  } hsf_sched_t;

  // Per-port levels
  typedef struct packed {
    logic [NUM_PORTS-1:0] owner;
    logic [NUM_PORTS-1:0] change;
    logic [NUM_PORTS-1:0] force_resume;
    logic [NUM_PORTS-1:0] connect_change;
  } hsf_port_t;

endpackage

// [hw/hsf_status_flags.sv]
// Host event status, interrupt enable and run control over Wishbone
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module hsf_status_flags (
  input  wire logic                 I_CORE_CLK,
  input  wire logic                 I_RST_N,
  input  wire logic                 I_CLK_EN,
  input  wire logic                 I_WB_CYC,
  input  wire logic                 I_WB_STB,
  input  wire logic                 I_WB_WE,
  input  wire logic [7:0]           I_WB_ADR,
  input  wire logic [3:0]           I_WB_SEL,
  input  wire logic [31:0]          I_WB_DAT,
  output logic      [31:0]          O_WB_DAT,
  output logic                      O_WB_ACK,
  input  wire hsf_pkg::hsf_evt_t    I_EVT,
  input  wire hsf_pkg::hsf_sched_t  I_SCHED,
  input  wire hsf_pkg::hsf_port_t   I_PORT,
  output logic                      O_RUN_STOP,
  output logic                      O_DOORBELL_ARMED,
  output logic                      O_CONTROLLER_STOPPED,
  output logic [13:0]               O_FRAME_COUNTER,
  output logic                      O_IRQ
);
  import hsf_pkg::*;

  typedef enum {SEL_NONE, SEL_CMD, SEL_STS, SEL_IEN, SEL_FRM} hsf_sel_t;

  function automatic hsf_sel_t reg_sel(input logic [7:0] adr);
    if (adr == ADDR_COMMAND) begin
      reg_sel = SEL_CMD;
    end else if (adr == ADDR_STATUS) begin
      reg_sel = SEL_STS;
    end else if (adr == ADDR_INT_EN) begin
      reg_sel = SEL_IEN;
    end else if (adr == ADDR_FRAME) begin
      reg_sel = SEL_FRM;
    end else begin
      reg_sel = SEL_NONE;
    end
  endfunction

  logic                 wb_req;
  logic                 wb_commit;
  logic                 wr_cmd;
  logic                 wr_sts;
  logic                 wr_ien;
  logic [5:0]           flag;
  logic [5:0]           next_flag;
  logic [5:0]           flag_set;
  logic [5:0]           flag_clr;
  logic [5:0]           int_en;
  logic                 next_run_stop;
  logic [31:0]          status_word;
  logic [NUM_PORTS-1:0] change_q;
  logic [NUM_PORTS-1:0] resume_q;
  logic [NUM_PORTS-1:0] connect_q;
  logic [NUM_PORTS-1:0] port_hit;
  logic                 frame_wrap;

  assign wb_req    = I_WB_CYC & I_WB_STB;
  // Writes land on the edge where the master samples ack high
  assign wb_commit = wb_req & O_WB_ACK & I_WB_WE;
  assign wr_cmd    = wb_commit & (reg_sel(I_WB_ADR) == SEL_CMD);
  assign wr_sts    = wb_commit & (reg_sel(I_WB_ADR) == SEL_STS) & I_WB_SEL[0];
  assign wr_ien    = wb_commit & (reg_sel(I_WB_ADR) == SEL_IEN) & I_WB_SEL[0];

  // Bus handshake: ack for one cycle per request
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_WB_ACK <= 1'b0;
    end else if (I_CLK_EN) begin
      O_WB_ACK <= wb_req & ~O_WB_ACK;
    end
  end

  // Read data captured as ack rises
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_WB_DAT <= 32'h0000_0000;
    end else if (I_CLK_EN) begin
      if (wb_req & ~O_WB_ACK & ~I_WB_WE) begin
        case (reg_sel(I_WB_ADR))
          SEL_CMD: begin
            O_WB_DAT <= {25'h0000000, O_DOORBELL_ARMED, 5'h00, O_RUN_STOP};
          end
          SEL_STS: begin
            O_WB_DAT <= status_word;
          end
          SEL_IEN: begin
            O_WB_DAT <= {26'h0000000, int_en};
          end
          SEL_FRM: begin
            O_WB_DAT <= {18'h00000, O_FRAME_COUNTER};
          end
          default: begin
            O_WB_DAT <= 32'h0000_0000;
          end
        endcase
      end else begin
        O_WB_DAT <= 32'h0000_0000;
      end
    end
  end

  always_comb begin
    status_word              = 32'h0000_0000; // [R06]
    status_word[ST_ASYNC]    = I_SCHED.async_sched_active; // [R01]
    status_word[ST_PERIODIC] = I_SCHED.periodic_sched_active; // [R02]
    status_word[ST_EMPTY]    = I_SCHED.empty_list_detect; // [R03]
    status_word[ST_STOPPED]  = O_CONTROLLER_STOPPED;
    status_word[5:0]         = flag;
  end

  // Run control: software write or hardware stop
  always_comb begin
    next_run_stop = O_RUN_STOP;
    if (wr_cmd & I_WB_SEL[0]) begin
      next_run_stop = I_WB_DAT[CMD_RUN_STOP];
    end
    if (I_SCHED.hw_stop) begin
      next_run_stop = 1'b0;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_RUN_STOP <= 1'b0;
    end else if (I_CLK_EN) begin
      O_RUN_STOP <= next_run_stop; // [R17]
    end
  end

  // Stopped flag follows run_stop and engine idle
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_CONTROLLER_STOPPED <= STOPPED_RESET;
    end else if (I_CLK_EN) begin
      if (next_run_stop) begin
        O_CONTROLLER_STOPPED <= 1'b0; // [R04]
      end else if (I_SCHED.engine_idle) begin
        O_CONTROLLER_STOPPED <= 1'b1; // [R05]
      end
    end
  end

  // Doorbell stays armed until the next async advance
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_DOORBELL_ARMED <= 1'b0;
    end else if (I_CLK_EN) begin
      if (wr_cmd & I_WB_SEL[0] & I_WB_DAT[CMD_DOORBELL]) begin
        O_DOORBELL_ARMED <= 1'b1; // [R18]
      end else if (I_EVT.async_advance) begin
        O_DOORBELL_ARMED <= 1'b0;
      end
    end
  end

  // Frame counter, wrap is the rollover event
  assign frame_wrap = I_EVT.frame_end & (&O_FRAME_COUNTER);

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_FRAME_COUNTER <= 14'h0000;
    end else if (I_CLK_EN) begin
      if (I_EVT.frame_end) begin
        O_FRAME_COUNTER <= O_FRAME_COUNTER + 14'h0001; // [R19]
      end
    end
  end

  // Port edge detection
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      change_q  <= '0;
      resume_q  <= '0;
      connect_q <= '0;
    end else if (I_CLK_EN) begin
      change_q  <= I_PORT.change;
      resume_q  <= I_PORT.force_resume;
      connect_q <= I_PORT.connect_change;
    end
  end

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_port
      assign port_hit[p] =
          (~I_PORT.owner[p] & I_PORT.change[p] & ~change_q[p]) // [R10]
        | (~I_PORT.owner[p] & I_PORT.force_resume[p]
           & ~resume_q[p]) // [R11]
        | (I_PORT.owner[p] & I_PORT.connect_change[p]
           & ~connect_q[p]); // [R12]
    end
  endgenerate

  always_comb begin
    flag_set             = 6'h00;
    flag_set[ST_ADVANCE] = I_EVT.async_advance & O_DOORBELL_ARMED; // [R07]
    flag_set[ST_FAULT]   = I_EVT.bus_fault; // [R08]
    flag_set[ST_WRAP]    = frame_wrap; // [R09]
    flag_set[ST_PORT]    = |port_hit; // [R10]
    flag_set[ST_ERROR]   = I_EVT.xfer_error; // [R13]
    flag_set[ST_DONE]    = I_EVT.xfer_done & I_EVT.irq_on_complete; // [R14]
    flag_clr             = wr_sts ? I_WB_DAT[5:0] : 6'h00;
    // Set wins over a same-cycle clear
    next_flag            = (flag & ~flag_clr) | flag_set; // [R07]
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      flag <= FLAGS_RESET;
    end else if (I_CLK_EN) begin
      flag <= next_flag;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      int_en <= INT_EN_RESET; // [R15]
    end else if (I_CLK_EN) begin
      if (wr_ien) begin
        int_en <= I_WB_DAT[5:0];
      end
    end
  end

  // Interrupt rises at a threshold tick, holds until no enabled flag stays set
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_IRQ <= 1'b0;
    end else if (I_CLK_EN) begin
      if (~|(next_flag & int_en)) begin
        O_IRQ <= 1'b0;
      end else if (I_EVT.threshold_tick) begin
        O_IRQ <= 1'b1; // [R16]
      end
    end
  end

endmodule // hsf_status_flags
`default_nettype wire

// [test/hsf_status_flags_props.sv]
// Assertion checker for the host event status flag block
`timescale 1ns/1ps
`default_nettype none
module hsf_status_flags_props (
  input wire logic               I_CORE_CLK,
  input wire logic               I_RST_N,
  input wire logic               I_CLK_EN,
  input wire logic               I_WB_WE,
  input wire logic [7:0]         I_WB_ADR,
  input wire logic [3:0]         I_WB_SEL,
  input wire logic [31:0]        I_WB_DAT,
  input wire logic [31:0]        O_WB_DAT,
  input wire logic               O_WB_ACK,
  input wire hsf_pkg::hsf_evt_t   I_EVT,
  input wire hsf_pkg::hsf_sched_t I_SCHED,
  input wire logic               O_RUN_STOP,
  input wire logic               O_CONTROLLER_STOPPED,
  input wire logic [13:0]        O_FRAME_COUNTER,
  input wire logic               O_IRQ
);
  import hsf_pkg::*;
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N || !I_CLK_EN);
  wire rd_st = O_WB_ACK && !I_WB_WE && I_WB_ADR == ADDR_STATUS;
  wire wr_cmd = O_WB_ACK && I_WB_WE && I_WB_ADR == ADDR_COMMAND;

  a_halt_while_run: assert property (
    O_RUN_STOP |-> !O_CONTROLLER_STOPPED) else $error("halt while run");
  a_halt_needs_idle: assert property (
    $rose(O_CONTROLLER_STOPPED) |-> $past(I_SCHED.engine_idle)
      && !O_RUN_STOP) else $error("halt before idle");
  a_status_live_bits: assert property (
    rd_st |-> O_WB_DAT[15:12] == {$past(I_SCHED.async_sched_active),
      $past(I_SCHED.periodic_sched_active),
      $past(I_SCHED.empty_list_detect), $past(O_CONTROLLER_STOPPED)})
    else $error("live status bits wrong");
  a_status_rsvd_zero: assert property (
    rd_st |-> O_WB_DAT[31:16] == 16'h0 && O_WB_DAT[11:6] == 6'h0)
    else $error("reserved bits set");
  a_frame_step: assert property (
    I_EVT.frame_end |=> O_FRAME_COUNTER == $past(O_FRAME_COUNTER) + 14'h1)
    else $error("frame counter step wrong");
  a_frame_hold: assert property (
    !I_EVT.frame_end |=> $stable(O_FRAME_COUNTER)) else $error("frame moved");
  a_irq_on_tick: assert property (
    $rose(O_IRQ) |-> $past(I_EVT.threshold_tick)) else $error("irq no tick");
  a_run_write: assert property (
    wr_cmd && I_WB_SEL[0] && !I_SCHED.hw_stop |=>
      O_RUN_STOP == $past(I_WB_DAT[0])) else $error("run write lost");

  c_irq: cover property (O_IRQ);
  c_wrap: cover property (I_EVT.frame_end && O_FRAME_COUNTER == 14'h3fff);
  c_stop: cover property ($rose(O_CONTROLLER_STOPPED));
endmodule // hsf_status_flags_props

bind hsf_status_flags hsf_status_flags_props u_props (.I_CORE_CLK, .I_RST_N,
  .I_CLK_EN, .I_WB_WE, .I_WB_ADR, .I_WB_SEL, .I_WB_DAT, .O_WB_DAT, .O_WB_ACK,
  .I_EVT, .I_SCHED, .O_RUN_STOP, .O_CONTROLLER_STOPPED, .O_FRAME_COUNTER,
  .O_IRQ);
`default_nettype wire

// [test/tb_hsf_status_flags.sv]
// Self-checking bench for the host event status flag block
`timescale 1ns/1ps
`default_nettype none
module tb_hsf_status_flags;
  import hsf_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n, cyc, stb, we, ack, run, halt, irq, bell, ce;
  logic [3:0]  sel;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, q;
  logic [13:0] frame;
  hsf_evt_t    evt;
  hsf_sched_t  sched;
  hsf_port_t   port;
  int          num_errors = 0;
  int          num_checks = 0;
  logic [6:0]  ev [8] = '{7'h03, 7'h04, 7'h0, 7'h0, 7'h0, 7'h08, 7'h10, 7'h10};
  logic [7:0]  pt [8] = '{8'h0, 8'h0, 8'h10, 8'h04, 8'h41, 8'h0, 8'h0, 8'h0};
  logic [5:0]  ex [8] = '{6'h01, 6'h02, 6'h04, 6'h04, 6'h04, 6'h10, 6'h0, 6'h20};

  always #12.5 clk = ~clk;

  hsf_status_flags u_dut (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_CLK_EN(ce),
    .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr),
    .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
    .I_EVT(evt), .I_SCHED(sched), .I_PORT(port), .O_RUN_STOP(run),
    .O_DOORBELL_ARMED(bell), .O_CONTROLLER_STOPPED(halt),
    .O_FRAME_COUNTER(frame), .O_IRQ(irq));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    q = rdat;
    {cyc, stb} <= 2'h0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  task automatic fire(input logic [6:0] e, input logic [7:0] p);
    evt <= hsf_evt_t'(e);
    port <= hsf_port_t'(p);
    @(posedge clk);
    evt <= '0;
    port <= '0;
    @(posedge clk);
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    report_and_stop;
  end

  initial begin
    {rst_n, cyc, stb, we, adr, wdat, evt, sched, port} = '0;
    ce = 1'b1;
    sel = 4'hf;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rchk(ADDR_STATUS, STATUS_RESET);
    rchk(ADDR_INT_EN, 32'h0);
    rchk(8'h40, 32'h0);
    wb(1'b1, ADDR_INT_EN, 32'hffff_ffff);
    rchk(ADDR_INT_EN, 32'h3f);
    wb(1'b1, ADDR_INT_EN, 32'h0);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      if (i == 7) begin
        wb(1'b1, ADDR_COMMAND, 32'h40);
        rchk(ADDR_COMMAND, 32'h40);
        chk(bell, 1'b1);
      end
      fire(ev[i], pt[i]);
      rchk(ADDR_STATUS, {26'h40, ex[i]});
      wb(1'b1, ADDR_STATUS, 32'hffff_ffff);
      rchk(ADDR_STATUS, STATUS_RESET);
    end
    rchk(ADDR_COMMAND, 32'h0);
    chk(bell, 1'b0);
    fire(7'h02, 8'h0);
    rchk(ADDR_STATUS, STATUS_RESET);
    fire(7'h04, 8'h0);
    sel <= 4'he;
    wb(1'b1, ADDR_STATUS, 32'h2);
    sel <= 4'hf;
    rchk(ADDR_STATUS, 32'h1002);
    wb(1'b1, ADDR_STATUS, 32'h2);
    rchk(ADDR_STATUS, STATUS_RESET);
    $display("event test done");
    repeat (16383) fire(7'h20, 8'h0);
    rchk(ADDR_FRAME, 32'h3fff);
    rchk(ADDR_STATUS, STATUS_RESET);
    fire(7'h20, 8'h0);
    rchk(ADDR_FRAME, 32'h0);
    rchk(ADDR_STATUS, 32'h1008);
    wb(1'b1, ADDR_STATUS, 32'h8);
    $display("wrap test done");
    fire(7'h04, 8'h0);
    fire(7'h40, 8'h0);
    chk(irq, 1'b0);
    wb(1'b1, ADDR_INT_EN, 32'h2);
    chk(irq, 1'b0);
    fire(7'h40, 8'h0);
    chk(irq, 1'b1);
    wb(1'b1, ADDR_STATUS, 32'h2);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    $display("irq test done");
    wb(1'b1, ADDR_COMMAND, 32'h1);
    @(posedge clk);
    chk({run, halt}, 2'h2);
    wb(1'b1, ADDR_COMMAND, 32'h0);
    repeat (4) @(posedge clk);
    chk({run, halt}, 2'h0);
    sched <= 5'h1e;
    repeat (2) @(posedge clk);
    rchk(ADDR_STATUS, 32'hf000);
    wb(1'b1, ADDR_COMMAND, 32'h1);
    @(posedge clk);
    chk({run, halt}, 2'h2);
    sched <= 5'h03;
    repeat (3) @(posedge clk);
    chk({run, halt}, 2'h1);
    $display("run test done");
    ce <= 1'b0;
    fire(7'h24, 8'h0);
    ce <= 1'b1;
    rchk(ADDR_FRAME, 32'h0);
    rchk(ADDR_STATUS, 32'h1000);
    $display("enable test done");
    report_and_stop;
  end
endmodule // tb_hsf_status_flags
`default_nettype wire
